// ==== hdl/usmt_defs.vh ====
`ifndef USMT_DEFS_VH
`define USMT_DEFS_VH

// register byte addresses
`define USMT_ADDR_PFLAG 8'h0C
`define USMT_ADDR_PMASK 8'h8C
`define USMT_ADDR_RXSC 8'h18
`define USMT_ADDR_TXSC 8'h04
`define USMT_ADDR_TXBUF 8'h08
`define USMT_ADDR_BAUD 8'h10
`define USMT_ADDR_RXBUF 8'h1C

// transmit status/control fields
`define USMT_TXSC_CKSEL 7
`define USMT_TXSC_NINE 6
`define USMT_TXSC_TXON 5
`define USMT_TXSC_SYNC 4
`define USMT_TXSC_SHEMPTY 1
`define USMT_TXSC_BIT9 0

// receive status/control fields
`define USMT_RXSC_PORT 7
`define USMT_RXSC_RNINE 6
`define USMT_RXSC_SINGLE 5
`define USMT_RXSC_CONT 4
`define USMT_RXSC_ADET 3
`define USMT_RXSC_FRAME 2
`define USMT_RXSC_OVRN 1
`define USMT_RXSC_RBIT9 0

// flag and mask position of the buffer-empty event
`define USMT_PFLAG_TXE 4

// reset values
`define USMT_TXSC_RESET 8'h02
`define USMT_RXSC_RESET 8'h00
`define USMT_BAUD_RESET 8'h00

// word lengths in bits
`define USMT_BITS_8 4'h8
`define USMT_BITS_9 4'h9

// bus responses
`define USMT_RESP_OKAY 2'b00
`define USMT_RESP_SLVERR 2'b10

`endif

// ==== hdl/usmt_top.v ====
`timescale 1ns/100ps
`include "usmt_defs.vh"

module usmt_top (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // axi4-lite write address
    input wire awvalid,
    output reg awready,
    input wire [7:0] awaddr,
    // axi4-lite write data
    input wire wvalid,
    output reg wready,
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    // axi4-lite write response
    output reg bvalid,
    input wire bready,
    output reg [1:0] bresp,
    // axi4-lite read address
    input wire arvalid,
    output reg arready,
    input wire [7:0] araddr,
    // axi4-lite read data
    output reg rvalid,
    input wire rready,
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    // serial clock line
    output reg serial_clk_line_o,
    output reg serial_clk_line_oe,
    // serial data line
    input wire serial_data_line_i,
    output reg serial_data_line_o,
    output reg serial_data_line_oe,
    // transmit interrupt
    output reg tx_irq
);

    // word length for the selected mode
    function [3:0] usmt_nbits;
        input nine;
        begin
            usmt_nbits = nine ? `USMT_BITS_9 : `USMT_BITS_8;
        end
    endfunction

    // control and status registers
    reg clock_source_select_q;
    reg nine_bit_transmit_select_q;
    reg transmit_enable_q;
    reg sync_mode_q;
    reg transmit_ninth_bit_q;
    reg serial_port_enable_q;
    reg nine_bit_receive_select_q;
    reg single_receive_q;
    reg continuous_receive_q;
    reg address_detect_enable_q;
    reg overrun_error_q;
    reg received_ninth_bit_q;
    reg transmit_buffer_empty_flag_q;
    reg transmit_interrupt_enable_q;
    reg [7:0] baud_divisor_q;
    reg [7:0] transmit_buffer_q;
    reg [7:0] receive_buffer_q;
    reg rx_full_q;

    // transmitter state
    reg [8:0] transmit_shift_register_q;
    reg shift_register_empty_q;
    reg [3:0] tx_idx_q;
    reg tx_started_q;

    // receiver state
    reg [8:0] rx_shift_q;
    reg [3:0] rx_cnt_q;

    // baud generator and clock phase
    reg [7:0] baud_cnt_q;
    reg clk_phase_q;

    // data line synchroniser
    reg din_s1_q;
    reg din_s2_q;

    // bus slave state
    reg aw_hold_q;
    reg w_hold_q;
    reg [7:0] awaddr_q;
    reg [7:0] wdata_q;
    reg wstrb0_q;

    // half-duplex: any receive enable takes the line
    wire rx_mode = continuous_receive_q | single_receive_q;
    wire baud_run = transmit_enable_q | rx_mode;
    wire port_on = serial_port_enable_q & sync_mode_q;
    wire baud_tick = baud_run && (baud_cnt_q == 8'h00);
    wire tx_active = transmit_enable_q & ~shift_register_empty_q & ~rx_mode;
    wire clk_run = tx_active | rx_mode;
    wire rise = baud_tick & clk_run & ~clk_phase_q;
    wire fall = baud_tick & clk_run & clk_phase_q;
    wire [3:0] tx_len = usmt_nbits(nine_bit_transmit_select_q);
    wire [3:0] rx_len = usmt_nbits(nine_bit_receive_select_q);

    // bus decode of a completed write
    wire wr_fire = aw_hold_q & w_hold_q & ~bvalid;
    wire wr_en = wr_fire & wstrb0_q;
    wire wr_txsc = wr_en && (awaddr_q == `USMT_ADDR_TXSC);
    wire wr_txbuf = wr_en && (awaddr_q == `USMT_ADDR_TXBUF);
    wire wr_pmask = wr_en && (awaddr_q == `USMT_ADDR_PMASK);
    wire wr_baud = wr_en && (awaddr_q == `USMT_ADDR_BAUD);
    wire wr_rxsc = wr_en && (awaddr_q == `USMT_ADDR_RXSC);
    wire rd_fire = arvalid & arready;

    // load needs an empty shifter and a full buffer
    wire tx_load = transmit_enable_q & shift_register_empty_q & ~transmit_buffer_empty_flag_q;
    wire rx_done = rx_mode & fall && (rx_cnt_q == rx_len - 4'h1);

    // address check shared by reads and writes
    function usmt_mapped;
        input [7:0] a;
        begin
            if (a == `USMT_ADDR_TXSC) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_TXBUF) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_PFLAG) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_PMASK) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_BAUD) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_RXSC) usmt_mapped = 1'b1;
            else if (a == `USMT_ADDR_RXBUF) usmt_mapped = 1'b1;
            else usmt_mapped = 1'b0;
        end
    endfunction

    // read mux over the register file
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (araddr == `USMT_ADDR_TXSC) begin
            rd_byte[`USMT_TXSC_CKSEL] = clock_source_select_q;
            rd_byte[`USMT_TXSC_NINE] = nine_bit_transmit_select_q;
            rd_byte[`USMT_TXSC_TXON] = transmit_enable_q;
            rd_byte[`USMT_TXSC_SYNC] = sync_mode_q;
            rd_byte[`USMT_TXSC_SHEMPTY] = shift_register_empty_q;
            rd_byte[`USMT_TXSC_BIT9] = transmit_ninth_bit_q;
        end else if (araddr == `USMT_ADDR_TXBUF) begin
            rd_byte = transmit_buffer_q;
        end else if (araddr == `USMT_ADDR_PFLAG) begin
            rd_byte[`USMT_PFLAG_TXE] = transmit_buffer_empty_flag_q;
        end else if (araddr == `USMT_ADDR_PMASK) begin
            rd_byte[`USMT_PFLAG_TXE] = transmit_interrupt_enable_q;
        end else if (araddr == `USMT_ADDR_BAUD) begin
            rd_byte = baud_divisor_q;
        end else if (araddr == `USMT_ADDR_RXSC) begin
            rd_byte[`USMT_RXSC_PORT] = serial_port_enable_q;
            rd_byte[`USMT_RXSC_RNINE] = nine_bit_receive_select_q;
            rd_byte[`USMT_RXSC_SINGLE] = single_receive_q;
            rd_byte[`USMT_RXSC_CONT] = continuous_receive_q;
            rd_byte[`USMT_RXSC_ADET] = address_detect_enable_q;
            rd_byte[`USMT_RXSC_FRAME] = 1'b0;
            rd_byte[`USMT_RXSC_OVRN] = overrun_error_q;
            rd_byte[`USMT_RXSC_RBIT9] = received_ninth_bit_q;
        end else if (araddr == `USMT_ADDR_RXBUF) begin
            rd_byte = receive_buffer_q;
        end
    end

    // write channels are taken independently, answered together
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `USMT_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q <= awaddr;
                awready <= 1'b0;
            end else if (!aw_hold_q && !bvalid) begin
                awready <= 1'b1;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wdata_q <= wdata[7:0];
                wstrb0_q <= wstrb[0];
                wready <= 1'b0;
            end else if (!w_hold_q && !bvalid) begin
                wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= usmt_mapped(awaddr_q) ? `USMT_RESP_OKAY : `USMT_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read channel: one cycle from address to data
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `USMT_RESP_OKAY;
        end else if (rd_fire) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= {24'h00_0000, rd_byte};
            rresp <= usmt_mapped(araddr) ? `USMT_RESP_OKAY : `USMT_RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else if (!rvalid) begin
            arready <= 1'b1;
        end
    end

    // software-written control bits
    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_source_select_q <= 1'b0;
            nine_bit_transmit_select_q <= 1'b0;
            transmit_enable_q <= 1'b0;
            sync_mode_q <= 1'b0;
            transmit_ninth_bit_q <= 1'b0;
            serial_port_enable_q <= 1'b0;
            nine_bit_receive_select_q <= 1'b0;
            address_detect_enable_q <= 1'b0;
            continuous_receive_q <= 1'b0;
            transmit_interrupt_enable_q <= 1'b0;
            baud_divisor_q <= `USMT_BAUD_RESET;
        end else begin
            if (wr_txsc) begin
                clock_source_select_q <= wdata_q[`USMT_TXSC_CKSEL];
                nine_bit_transmit_select_q <= wdata_q[`USMT_TXSC_NINE];
                transmit_enable_q <= wdata_q[`USMT_TXSC_TXON];
                sync_mode_q <= wdata_q[`USMT_TXSC_SYNC];
                transmit_ninth_bit_q <= wdata_q[`USMT_TXSC_BIT9];
            end
            if (wr_rxsc) begin
                serial_port_enable_q <= wdata_q[`USMT_RXSC_PORT];
                nine_bit_receive_select_q <= wdata_q[`USMT_RXSC_RNINE];
                continuous_receive_q <= wdata_q[`USMT_RXSC_CONT];
                address_detect_enable_q <= wdata_q[`USMT_RXSC_ADET];
            end
            if (wr_pmask)
                transmit_interrupt_enable_q <= wdata_q[`USMT_PFLAG_TXE];
            if (wr_baud)
                baud_divisor_q <= wdata_q;
        end
    end

    // transmit buffer and its empty flag; a write beats a same-cycle load
    always @(posedge aclk) begin
        if (!aresetn) begin
            transmit_buffer_q <= 8'h00;
            transmit_buffer_empty_flag_q <= 1'b1;
        end else if (wr_txbuf) begin
            transmit_buffer_q <= wdata_q;
            transmit_buffer_empty_flag_q <= 1'b0;
        end else if (tx_load) begin
            transmit_buffer_empty_flag_q <= 1'b1;
        end
    end

    // interrupt forwarding, no global gate inside the block
    always @(posedge aclk) begin
        if (!aresetn)
            tx_irq <= 1'b0;
        else
            tx_irq <= transmit_buffer_empty_flag_q & transmit_interrupt_enable_q;
    end

    // baud generator: reload from the divisor, cleared while idle
    always @(posedge aclk) begin
        if (!aresetn || !baud_run) begin
            baud_cnt_q <= 8'h00;
            clk_phase_q <= 1'b0;
        end else begin
            baud_cnt_q <= baud_tick ? baud_divisor_q : baud_cnt_q - 8'h01;
            if (baud_tick && clk_run)
                clk_phase_q <= ~clk_phase_q;
        end
    end

    // transmit shifter; frozen, not reset, while receiving
    always @(posedge aclk) begin
        if (!aresetn || !transmit_enable_q) begin
            transmit_shift_register_q <= 9'h000;
            shift_register_empty_q <= 1'b1;
            tx_idx_q <= 4'h0;
            tx_started_q <= 1'b0;
            serial_data_line_o <= 1'b0;
        end else if (tx_load) begin
            transmit_shift_register_q <= {transmit_ninth_bit_q, transmit_buffer_q};
            shift_register_empty_q <= 1'b0;
            tx_idx_q <= 4'h0;
            tx_started_q <= 1'b0;
        end else if (tx_active && rise) begin
            serial_data_line_o <= transmit_shift_register_q[tx_idx_q];
            tx_idx_q <= tx_idx_q + 4'h1;
            tx_started_q <= 1'b1;
        end else if (tx_active && fall && tx_started_q && tx_idx_q == tx_len) begin
            shift_register_empty_q <= 1'b1;
        end
    end

    // data line synchroniser; only the second stage is read
    always @(posedge aclk) begin
        if (!aresetn) begin
            din_s1_q <= 1'b0;
            din_s2_q <= 1'b0;
        end else begin
            din_s1_q <= serial_data_line_i;
            din_s2_q <= din_s1_q;
        end
    end

    // receiver samples on the falling clock; single receive self-clears
    always @(posedge aclk) begin
        if (!aresetn) begin
            rx_shift_q <= 9'h000;
            rx_cnt_q <= 4'h0;
            receive_buffer_q <= 8'h00;
            received_ninth_bit_q <= 1'b0;
            rx_full_q <= 1'b0;
            overrun_error_q <= 1'b0;
            single_receive_q <= 1'b0;
        end else begin
            if (!rx_mode)
                rx_cnt_q <= 4'h0;
            else if (fall) begin
                rx_shift_q[rx_cnt_q] <= din_s2_q;
                rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
            end
            if (wr_rxsc)
                single_receive_q <= wdata_q[`USMT_RXSC_SINGLE];
            if (rx_done) begin
                receive_buffer_q <= rx_shift_q[7:0];
                received_ninth_bit_q <= nine_bit_receive_select_q ? din_s2_q : 1'b0;
                if (!continuous_receive_q && !(wr_rxsc && wdata_q[`USMT_RXSC_CONT]))
                    single_receive_q <= 1'b0;
            end
            // a new word beats the read that frees the buffer
            if (rx_done)
                rx_full_q <= 1'b1;
            else if (rd_fire && araddr == `USMT_ADDR_RXBUF)
                rx_full_q <= 1'b0;
            // overrun sets over the clear made by dropping continuous receive
            if (rx_done && rx_full_q)
                overrun_error_q <= 1'b1;
            else if (wr_rxsc && !wdata_q[`USMT_RXSC_CONT])
                overrun_error_q <= 1'b0;
        end
    end

    // pin drivers, registered so the outputs come from flip-flops
    always @(posedge aclk) begin
        if (!aresetn) begin
            serial_clk_line_o <= 1'b0;
            serial_clk_line_oe <= 1'b0;
            serial_data_line_oe <= 1'b0;
        end else begin
            // clock takes its new phase at the tick, the same edge that moves data
            serial_clk_line_o <= clk_phase_q ^ (baud_tick & clk_run);
            serial_clk_line_oe <= port_on & clock_source_select_q & baud_run;
            serial_data_line_oe <= port_on & transmit_enable_q & ~rx_mode;
        end
    end

endmodule // usmt_top

// ==== tb/usmt_top_sva.sv ====
`timescale 1ns/100ps
`include "usmt_defs.vh"
module usmt_chk (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // register bus
    input wire awvalid,
    input wire awready,
    input wire [7:0] awaddr,
    input wire wvalid,
    input wire wready,
    input wire [31:0] wdata,
    input wire bvalid,
    input wire bready,
    // pins and interrupt
    input wire serial_clk_line_o,
    input wire serial_clk_line_oe,
    input wire serial_data_line_o,
    input wire serial_data_line_oe,
    input wire tx_irq
);
    reg [7:0] a_q, d_q, baud_q, mask_q, rx_q;
    reg [8:0] hi_q;
    // shadows follow completed writes, a cycle behind the design
    always @(posedge aclk) begin
        if (!aresetn) begin
            {a_q, d_q, baud_q, mask_q, rx_q} <= 40'h00_0000_0000;
            hi_q <= 9'h000;
        end else begin
            hi_q <= serial_clk_line_o ? hi_q + 9'h001 : 9'h000;
            if (awvalid && awready) a_q <= awaddr;
            if (wvalid && wready) d_q <= wdata[7:0];
            if ($rose(bvalid) && a_q == `USMT_ADDR_BAUD) baud_q <= d_q;
            if ($rose(bvalid) && a_q == `USMT_ADDR_PMASK) mask_q <= d_q;
            if ($rose(bvalid) && a_q == `USMT_ADDR_RXSC) rx_q <= d_q;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_one_resp;
        bvalid && bready |=> !bvalid;
    endproperty
    a_one_resp: assert property (p_one_resp) else $error("write answered twice");
    property p_hi;
        $fell(serial_clk_line_o) && serial_clk_line_oe && $past(serial_clk_line_oe) |-> hi_q == {1'h0, baud_q} + 9'h001;
    endproperty
    a_hi: assert property (p_hi) else $error("clock high phase length off");
    property p_fall_stable;
        $fell(serial_clk_line_o) && serial_data_line_oe && $past(serial_data_line_oe) |-> $stable(serial_data_line_o);
    endproperty
    a_fall_stable: assert property (p_fall_stable) else $error("data moved at falling clock");
    property p_move_on_rise;
        serial_data_line_oe && $past(serial_data_line_oe) && $changed(serial_data_line_o) |-> $rose(serial_clk_line_o);
    endproperty
    a_move_on_rise: assert property (p_move_on_rise) else $error("data moved off the rising clock");
    property p_irq_mask;
        tx_irq |-> mask_q[4] || $past(mask_q[4]);
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt while masked");
    property p_transmit_enable_off;
        $rose(bvalid) && a_q == `USMT_ADDR_TXSC && !d_q[5] && rx_q[5:4] == 2'h0
            |-> ##[0:2] (!serial_clk_line_oe && !serial_data_line_oe);
    endproperty
    a_transmit_enable_off: assert property (p_transmit_enable_off) else $error("lines still driven after disable");
    property p_rx_abort;
        $rose(bvalid) && a_q == `USMT_ADDR_RXSC && d_q[4] && serial_data_line_oe && serial_clk_line_oe
            |-> ##[0:2] (!serial_data_line_oe && serial_clk_line_oe);
    endproperty
    a_rx_abort: assert property (p_rx_abort) else $error("receive did not float data only");
    property p_half_duplex;
        rx_q[4] && $past(rx_q[4]) && $past(rx_q[4], 2) |-> !serial_data_line_oe;
    endproperty
    a_half_duplex: assert property (p_half_duplex) else $error("data driven while receiving");
    c_irq: cover property (tx_irq);
    c_abort: cover property ($fell(serial_data_line_oe) && serial_clk_line_oe);
    c_shift: cover property ($rose(serial_clk_line_o));
endmodule // usmt_chk
bind usmt_top usmt_chk usmt_chk_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid), .bready(bready),
    .serial_clk_line_o(serial_clk_line_o), .serial_clk_line_oe(serial_clk_line_oe),
    .serial_data_line_o(serial_data_line_o), .serial_data_line_oe(serial_data_line_oe), .tx_irq(tx_irq));

// ==== tb/usmt_slave_model.sv ====
`timescale 1ns/100ps
module usmt_slave_model (
    // system clock for the idle pattern
    input wire aclk,
    // serial lines seen by the slave
    input wire sclk,
    input wire sdata,
    input wire sdata_oe,
    input wire clr,
    // slave side of the data line
    output logic sdata_drv
);
    logic [15:0] word = 16'h0000;
    int nbits;
    // capture on the falling clock, where master data is settled
    always @(negedge sclk or posedge clr) begin
        if (clr) begin
            word = 16'h0000;
            nbits = 0;
        end else if (sdata_oe && nbits < 16) begin
            word[nbits] = sdata;
            nbits++;
        end
    end
    // released line toggles so a stale level never reads as valid
    initial sdata_drv = 1'h0;
    always @(posedge aclk) sdata_drv <= ~sdata_drv;
endmodule // usmt_slave_model

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "usmt_defs.vh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module tb_top;
    localparam logic [7:0] TXSC = `USMT_ADDR_TXSC, TXBUF = `USMT_ADDR_TXBUF, PFLAG = `USMT_ADDR_PFLAG;
    localparam logic [7:0] PMASK = `USMT_ADDR_PMASK, RXSC = `USMT_ADDR_RXSC, BAUD = `USMT_ADDR_BAUD;
    localparam logic [1:0] OK = `USMT_RESP_OKAY;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic serial_clk_line_o, serial_clk_line_oe, serial_data_line_o, serial_data_line_oe, tx_irq, clr, drv, n9, b9;
    logic [7:0] awaddr, araddr, d, ts;
    logic [31:0] wdata, rdata, rv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int num_errors, n_tests;
    // the data line resolves between master and slave
    wire sdi = serial_data_line_oe ? serial_data_line_o : drv;
    wire sclk = serial_clk_line_oe ? serial_clk_line_o : 1'h0;
    usmt_top usmt_top_inst (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .serial_clk_line_o(serial_clk_line_o), .serial_clk_line_oe(serial_clk_line_oe),
        .serial_data_line_i(sdi), .serial_data_line_o(serial_data_line_o),
        .serial_data_line_oe(serial_data_line_oe), .tx_irq(tx_irq));
    usmt_slave_model usmt_slave_model_inst (.aclk(aclk), .sclk(sclk), .sdata(sdi), .sdata_oe(serial_data_line_oe),
        .clr(clr), .sdata_drv(drv));
    // 100 MHz clock
    initial begin
        aclk = 1'h0;
        forever #5 aclk = ~aclk;
    end
    // write with address and data offered together
    task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] er);
        int t;
        begin
            t = 0;
            awaddr <= a;
            wdata <= {24'h00_0000, v};
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            do begin
                @(posedge aclk);
                t++;
                if (awvalid && awready) awvalid <= 1'h0;
                if (wvalid && wready) wvalid <= 1'h0;
            end while (!(bvalid && bready) && t < 200);
            `CHK(bresp, er)
            bready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    // read and compare the returned byte
    task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [7:0] ed);
        int t;
        begin
            t = 0;
            araddr <= a;
            arvalid <= 1'h1;
            rready <= 1'h1;
            do begin
                @(posedge aclk);
                t++;
                if (arvalid && arready) arvalid <= 1'h0;
            end while (!(rvalid && rready) && t < 200);
            `CHK(rresp, er)
            `CHK(rdata, {24'h00_0000, ed})
            rready <= 1'h0;
            @(posedge aclk);
        end
    endtask
    // bounded wait for the slave to count bits
    task automatic wait_bits(input int n);
        int t;
        begin
            t = 0;
            while (usmt_slave_model_inst.nbits < n && t < 3000) begin
                @(posedge aclk);
                t++;
            end
            `CHK(usmt_slave_model_inst.nbits, n)
        end
    endtask
    task automatic flush;
        begin
            clr <= 1'h1;
            @(posedge aclk);
            clr <= 1'h0;
            @(posedge aclk);
        end
    endtask
    // ninth bit goes in before the data byte
    task automatic send(input logic [7:0] v, input logic s9, input logic c9);
        begin
            wr(TXSC, {1'h1, s9, 2'h3, 3'h0, c9}, OK);
            wr(TXBUF, v, OK);
        end
    endtask
    function automatic logic [15:0] exp_word(input logic [7:0] v, input logic s9, input logic c9);
        return s9 ? {7'h00, c9, v} : {8'h00, v};
    endfunction
    task automatic end_of_test;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, num_errors);
            if (num_errors == 0 && n_tests > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    // watchdog: the tests need well under this
    initial begin
        #500us;
        num_errors++;
        end_of_test;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, clr, aresetn} = 7'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0000_0000;
        wstrb = 4'hf;
        num_errors = 0;
        n_tests = 0;
        rv = $urandom(32'h0986);
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(TXSC, OK, `USMT_TXSC_RESET);
        rd(PFLAG, OK, 8'h10);
        rd(PMASK, OK, 8'h00);
        rd(8'h40, `USMT_RESP_SLVERR, 8'h00);
        wr(8'h44, 8'hff, `USMT_RESP_SLVERR);
        wr(PFLAG, 8'h00, OK);
        rd(PFLAG, OK, 8'h10);
        wr(TXSC, 8'h00, OK);
        rd(TXSC, OK, 8'h02);
        wr(RXSC, 8'hc8, OK);
        rd(RXSC, OK, 8'hc8);
        $display("registers done");
        // buffer loaded before enable: the clock stays still
        rv = $urandom;
        wr(RXSC, 8'h80, OK);
        wr(BAUD, 8'h02, OK);
        wr(TXSC, 8'h90, OK);
        wr(TXBUF, rv[7:0], OK);
        repeat (30) @(posedge aclk);
        `CHK(sclk, 1'h0)
        wr(TXSC, 8'hb0, OK);
        wait_bits(8);
        `CHK(usmt_slave_model_inst.word, {8'h00, rv[7:0]})
        flush;
        repeat (30) @(posedge aclk);
        `CHK(usmt_slave_model_inst.nbits, 0)
        $display("enable order done");
        // random words, first one with a late ninth-bit update
        for (int i = 0; i < 6; i++) begin
            rv = $urandom;
            {b9, n9, d} = rv[9:0];
            if (i == 0) n9 = 1'h1;
            ts = {1'h1, n9, 2'h3, 3'h0, b9};
            flush;
            wr(BAUD, {6'h00, rv[11], 1'h1}, OK);
            send(d, n9, b9);
            if (i == 0) ts[0] = ~b9;
            if (i == 0) wr(TXSC, ts, OK);
            rd(PFLAG, OK, 8'h10);
            rd(TXSC, OK, ts);
            wait_bits(8 + n9);
            `CHK(usmt_slave_model_inst.word, exp_word(d, n9, b9))
            repeat (3) @(posedge aclk);
            rd(TXSC, OK, ts | 8'h02);
        end
        $display("random words done");
        // second word queued behind the first
        rv = $urandom;
        flush;
        send(rv[7:0], 1'h0, 1'h0);
        wr(TXBUF, rv[15:8], OK);
        rd(PFLAG, OK, 8'h00);
        wait_bits(16);
        `CHK(usmt_slave_model_inst.word, rv[15:0])
        rd(PFLAG, OK, 8'h10);
        `CHK(tx_irq, 1'h0)
        wr(PMASK, 8'h10, OK);
        repeat (2) @(posedge aclk);
        `CHK(tx_irq, 1'h1)
        wr(PMASK, 8'h00, OK);
        repeat (2) @(posedge aclk);
        `CHK(tx_irq, 1'h0)
        $display("back to back and interrupt done");
        // disable in mid-word
        flush;
        wr(BAUD, 8'h03, OK);
        send(rv[23:16], 1'h0, 1'h0);
        repeat (10) @(posedge aclk);
        wr(TXSC, 8'h90, OK);
        repeat (2) @(posedge aclk);
        `CHK({serial_clk_line_oe, serial_data_line_oe}, 2'h0)
        rd(TXSC, OK, 8'h92);
        // receive in mid-word freezes, then the word completes
        flush;
        send(rv[31:24], 1'h0, 1'h0);
        // switch right after a falling clock so no bit is left half sent
        repeat (12) @(posedge aclk);
        @(negedge sclk);
        wr(RXSC, 8'h90, OK);
        repeat (2) @(posedge aclk);
        `CHK({serial_clk_line_oe, serial_data_line_oe}, 2'h2)
        repeat (20) @(posedge aclk);
        @(negedge sclk);
        wr(RXSC, 8'h80, OK);
        wait_bits(8);
        `CHK(usmt_slave_model_inst.word, {8'h00, rv[31:24]})
        `CHK(serial_data_line_oe, 1'h1)
        wr(RXSC, 8'h00, OK);
        repeat (2) @(posedge aclk);
        `CHK(serial_data_line_oe, 1'h0)
        $display("abort done");
        end_of_test;
    end
endmodule // tb_top
